// [src/lpc_memory_cycle_target.sv]
// single-byte lpc memory read/write target sequencer
// assumes lad and frame are synchronous to sys_clk_in (the bus clock),
// user side answers rdata_in in the cycle req_valid_out is high
`timescale 1ns/1ps

// What this block does
// RULE1: accept only start nibble 0000 before frame rise
// RULE2: cycle type bits 3:2 01, bit1 direction
// RULE3: eight address nibbles, most significant first
// RULE4: address bits give identity and register space
// RULE5: host drives 1111 clock 11 on read
// RULE6: start driving clock 12 read, 14 write
// RULE7: read sync 0000 in clock 13
// RULE8: data byte low nibble first, then high
// RULE9: host drives 1111 clock 13 on write
// RULE10: write sync 0000 in clock 15
// RULE11: drive 1111 clock 16 then release
// RULE12: host owns bus from clock 17
// RULE13: fields sampled on rising bus clock edge
// RULE14: identity bits must equal inverted straps
// RULE15: frame low mid-cycle aborts to idle
// RULE16: host sets unused upper address bits to one
// RULE17: drivers released outside driving clocks
module lpc_memory_cycle_target import lpc_target_pkg::*; (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // lpc bus
    input wire logic [NIB_W-1:0] lad_in,
    input wire logic lframe_n_in,
    output logic [NIB_W-1:0] lad_out,
    output logic lad_oe_out,
    // identity straps
    input wire logic [STRAP_W-1:0] device_select_strap_in,
    // user side request
    output logic req_valid_out,
    output logic req_write_out,
    output logic req_reg_space_out,
    output logic [ADDR_W-1:0] req_addr_out,
    output logic [DATA_W-1:0] req_wdata_out,
    // user side read data
    input wire logic [DATA_W-1:0] rdata_in
);
    state_t state;
    state_t next_state;
    logic [NIB_W-1:0] last_nib;
    logic frame_q;
    logic [2:0] addr_cnt;
    logic is_write;
    logic [DATA_W-1:0] rdata_q;
    logic [NIB_W-1:0] next_lad;
    logic next_oe;
    logic next_req;
    logic [ADDR_W-1:0] addr;
    logic [STRAP_W-1:0] strap;

    wire start_ok;
    wire cyc_ok;
    wire accept;
    wire abort;
    wire addr_shift;
    wire addr_last;
    wire [STRAP_W-1:0] id_bits;
    wire id_match;
    wire drive_state;

    lpc_strap_sync #(
        .WIDTH(STRAP_W)
    ) u_strap (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(device_select_strap_in),
        .sync_out(strap)
    );

    lpc_addr_collect #(
        .NIBBLES(ADDR_NIBBLES)
    ) u_addr (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .shift_in(addr_shift),
        .nib_in(lad_in),
        .addr_out(addr)
    );

    // start nibble is the last one seen while frame was low
    assign start_ok = lframe_n_in && frame_q &&
        (last_nib == START_MEM_NIB); // RULE1
    assign cyc_ok = (lad_in[CYC_TYPE_HI:CYC_TYPE_LO] == CYC_MEM_BITS); // RULE2
    assign accept = (state == ST_IDLE) && start_ok && cyc_ok;
    assign abort = (state != ST_IDLE) && !lframe_n_in; // RULE15
    assign addr_shift = (state == ST_ADDR) && lframe_n_in; // RULE3
    assign addr_last = addr_shift && (addr_cnt == ADDR_LAST);
    // identity bits carry the inverted strap value
    assign id_bits = {addr[ID_HI_BIT:ID_LO_BIT], addr[ID_SOLO_BIT]}; // RULE4
    assign id_match = (id_bits == ~strap); // RULE14
    assign drive_state = (next_state == ST_TAR1) ||
        (next_state == ST_SYNC) || (next_state == ST_R_LO) ||
        (next_state == ST_R_HI) || (next_state == ST_DTAR);

    // sequencer: each state names the bus clock being sampled next
    always_comb begin
        next_state = state;
        if (abort) begin
            next_state = ST_IDLE; // RULE15
        end else begin
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        next_state = ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (addr_last) begin
                        next_state = is_write ? ST_W_LO : ST_R_TAR0;
                    end
                end
                ST_R_TAR0: begin
                    // host turnaround nibble is not checked
                    next_state = id_match ? ST_TAR1 : ST_IDLE; // RULE5
                end
                ST_W_LO: begin
                    next_state = id_match ? ST_W_HI : ST_IDLE; // RULE14
                end
                ST_W_HI: begin
                    next_state = ST_W_TAR0;
                end
                ST_W_TAR0: begin
                    next_state = ST_TAR1; // RULE9
                end
                ST_TAR1: begin
                    next_state = ST_SYNC;
                end
                ST_SYNC: begin
                    next_state = is_write ? ST_DTAR : ST_R_LO;
                end
                ST_R_LO: begin
                    next_state = ST_R_HI;
                end
                ST_R_HI: begin
                    next_state = ST_DTAR;
                end
                ST_DTAR: begin
                    next_state = ST_IDLE; // RULE12
                end
                default: begin
                    next_state = ST_IDLE;
                end
            endcase
        end
    end

    // bus drive values for the clock that follows the edge
    always_comb begin
        next_lad = TAR_NIB;
        case (next_state)
            ST_SYNC: next_lad = READY_SYNC_FIELD; // RULE7 RULE10
            ST_R_LO: next_lad = rdata_q[NIB_W-1:0]; // RULE8
            ST_R_HI: next_lad = rdata_q[DATA_W-1:NIB_W]; // RULE8
            default: next_lad = TAR_NIB; // RULE11
        endcase
    end

    assign next_oe = drive_state; // RULE6 RULE17
    assign next_req = !abort &&
        (((state == ST_R_TAR0) && id_match) || (state == ST_W_HI));

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            lad_out <= LAD_RST;
            lad_oe_out <= 1'b0;
        end else begin
            state <= next_state;
            lad_out <= next_lad;
            lad_oe_out <= next_oe;
        end
    end

    // start field tracking on every edge
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            frame_q <= 1'b0;
            last_nib <= TAR_NIB;
        end else begin
            frame_q <= !lframe_n_in;
            if (!lframe_n_in) begin
                last_nib <= lad_in; // RULE13
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            addr_cnt <= CNT_RST;
            is_write <= 1'b0;
        end else if (accept) begin
            addr_cnt <= CNT_RST;
            is_write <= lad_in[CYC_DIR_BIT]; // RULE2
        end else if (addr_shift) begin
            addr_cnt <= addr_cnt + 3'h1;
        end
    end

    // write data low nibble then high nibble
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            req_wdata_out <= DATA_RST;
        end else if ((state == ST_W_LO) && lframe_n_in) begin
            req_wdata_out[NIB_W-1:0] <= lad_in; // RULE8
        end else if ((state == ST_W_HI) && lframe_n_in) begin
            req_wdata_out[DATA_W-1:NIB_W] <= lad_in; // RULE8
        end
    end

    // read data taken while the request pulse stands
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_q <= DATA_RST;
        end else if (req_valid_out && !req_write_out) begin
            rdata_q <= rdata_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            req_valid_out <= 1'b0;
            req_write_out <= 1'b0;
            req_reg_space_out <= 1'b0;
            req_addr_out <= ADDR_RST;
        end else begin
            req_valid_out <= next_req;
            if (next_req) begin
                req_write_out <= is_write;
                // space bit low selects register space
                req_reg_space_out <= !addr[SPACE_BIT]; // RULE4
                req_addr_out <= addr;
            end
        end
    end

    // checks
    AST_START_NIBBLE: assert property (@(posedge sys_clk_in) // RULE1
        disable iff (!rst_n_in)
        (state == ST_IDLE && $past(state) == ST_IDLE) ##1
        (state == ST_ADDR) |-> $past(last_nib) == START_MEM_NIB)
        else $error("cycle accepted without 0000 start");

    AST_CYC_TYPE: assert property (@(posedge sys_clk_in) // RULE2
        disable iff (!rst_n_in)
        accept |=> (state == ST_ADDR) && addr_cnt == CNT_RST &&
            is_write == $past(lad_in[CYC_DIR_BIT]))
        else $error("cycle type not decoded");

    AST_ADDR_ORDER: assert property (@(posedge sys_clk_in) // RULE3
        disable iff (!rst_n_in)
        addr_shift |=> addr[NIB_W-1:0] == $past(lad_in) &&
            addr[2*NIB_W-1:NIB_W] == $past(addr[NIB_W-1:0]))
        else $error("address nibble order wrong");

    AST_ID_MISMATCH: assert property (@(posedge sys_clk_in) // RULE14
        disable iff (!rst_n_in)
        ((state == ST_R_TAR0 || state == ST_W_LO) && !id_match)
        |=> state == ST_IDLE && !lad_oe_out && !req_valid_out)
        else $error("mismatched identity not ignored");

    AST_READ_TAKEOVER: assert property (@(posedge sys_clk_in) // RULE6
        disable iff (!rst_n_in)
        (state == ST_R_TAR0 && id_match && lframe_n_in) |=>
            lad_oe_out && lad_out == TAR_NIB && req_valid_out)
        else $error("read turnaround takeover missing");

    AST_SYNC_VALUE: assert property (@(posedge sys_clk_in) // RULE7
        disable iff (!rst_n_in)
        (state == ST_TAR1 && lframe_n_in) |=>
            lad_oe_out && lad_out == READY_SYNC_FIELD)
        else $error("sync nibble not 0000");

    AST_WRITE_SYNC: assert property (@(posedge sys_clk_in) // RULE10
        disable iff (!rst_n_in)
        (state == ST_W_TAR0 && lframe_n_in) ##1 lframe_n_in |=>
            lad_oe_out && lad_out == READY_SYNC_FIELD)
        else $error("write sync missing at clock 15");

    AST_READ_DATA: assert property (@(posedge sys_clk_in) // RULE8
        disable iff (!rst_n_in)
        (state == ST_SYNC && !is_write && lframe_n_in) ##1
        lframe_n_in |=> lad_out == rdata_q[DATA_W-1:NIB_W])
        else $error("read data nibble order wrong");

    AST_CLOSE_TAR: assert property (@(posedge sys_clk_in) // RULE11
        disable iff (!rst_n_in)
        (state == ST_SYNC && is_write && lframe_n_in) |=>
            lad_oe_out && lad_out == TAR_NIB ##1 !lad_oe_out)
        else $error("closing turnaround wrong");

    AST_ABORT: assert property (@(posedge sys_clk_in) // RULE15
        disable iff (!rst_n_in)
        (state != ST_IDLE && !lframe_n_in) |=>
            state == ST_IDLE && !lad_oe_out)
        else $error("abort did not return to idle");

    AST_RELEASE: assert property (@(posedge sys_clk_in) // RULE17
        disable iff (!rst_n_in)
        lad_oe_out |-> $past(state) != ST_IDLE &&
            $past(state) != ST_ADDR)
        else $error("bus driven outside its clocks");

    COV_READ: cover property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        state == ST_R_HI ##1 state == ST_DTAR);
    COV_WRITE: cover property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        req_valid_out && req_write_out);
    COV_MISMATCH: cover property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        state == ST_R_TAR0 && !id_match);
    COV_ABORT: cover property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        state == ST_ADDR && !lframe_n_in);
endmodule

// [common/lpc_target_pkg.sv]
// constants and state type for the lpc memory cycle target
// assumes lad and frame pins are synchronous to sys_clk_in
package lpc_target_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 8;
    localparam int NIB_W = 4;
    localparam int STRAP_W = 4;
    localparam int ADDR_NIBBLES = 8;
    localparam int SYNC_STAGES = 2;
    // start, cycle type and fixed bus nibbles
    localparam logic [3:0] START_MEM_NIB = 4'h0;
    localparam logic [1:0] CYC_MEM_BITS = 2'h1;
    localparam int CYC_TYPE_HI = 3;
    localparam int CYC_TYPE_LO = 2;
    localparam int CYC_DIR_BIT = 1;
    localparam logic [3:0] READY_SYNC_FIELD = 4'h0;
    localparam logic [3:0] TAR_NIB = 4'hF;
    // identity and register-space positions in the address
    localparam int ID_HI_BIT = 25;
    localparam int ID_LO_BIT = 23;
    localparam int ID_SOLO_BIT = 21;
    localparam int SPACE_BIT = 22;
    // reset values
    localparam logic [3:0] LAD_RST = 4'hF;
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [STRAP_W-1:0] STRAP_RST = 4'h0;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [2:0] ADDR_LAST = 3'h7;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_R_TAR0,
        ST_W_LO,
        ST_W_HI,
        ST_W_TAR0,
        ST_TAR1,
        ST_SYNC,
        ST_R_LO,
        ST_R_HI,
        ST_DTAR
    } state_t;
endpackage

// [src/lpc_strap_sync.sv]
// two-flop synchroniser for static strap pins
// assumes straps change only while the bus is idle
`timescale 1ns/1ps
module lpc_strap_sync import lpc_target_pkg::*; #(
    parameter int WIDTH = STRAP_W
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // pins and synchronised copy
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_bad_width
        $error("strap width must be at least 1");
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            sync_out <= '0;
        end else begin
            meta <= pin_in;
            sync_out <= meta;
        end
    end
endmodule

// [src/lpc_addr_collect.sv]
// shifts address nibbles in, most significant first
// assumes shift_in is high once per address clock
`timescale 1ns/1ps
module lpc_addr_collect import lpc_target_pkg::*; #(
    parameter int NIBBLES = ADDR_NIBBLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // nibble stream
    input wire logic shift_in,
    input wire logic [NIB_W-1:0] nib_in,
    // collected address
    output logic [NIBBLES*NIB_W-1:0] addr_out
);
    logic [NIBBLES*NIB_W-1:0] next_addr;

    if (NIBBLES != ADDR_NIBBLES) begin : g_bad_nibbles
        $error("address must be 8 nibbles");
    end

    assign next_addr = {addr_out[(NIBBLES-1)*NIB_W-1:0], nib_in};

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            addr_out <= '0;
        end else if (shift_in) begin
            addr_out <= next_addr;
        end
    end
endmodule

// [testbench/lpc_host_model.sv]
// host-side model of the lpc bus facing the memory cycle target
// assumes the bench resolves the shared lad wire from both enables
`timescale 1ns/1ps
module lpc_host_model import lpc_target_pkg::*; (
    // clock
    input wire logic sys_clk_in,
    // resolved bus and target enable
    input wire logic [NIB_W-1:0] lad_bus_in,
    input wire logic lad_oe_in,
    // host drive
    output logic [NIB_W-1:0] host_lad_out,
    output logic host_oe_out,
    output logic lframe_n_out
);
    logic [NIB_W-1:0] seen [0:17];
    logic seen_oe [0:17];

    initial begin
        host_lad_out = 4'hF;
        host_oe_out = 1'b0;
        lframe_n_out = 1'b1;
    end

    // drive after falling edge, capture at rising edge
    task automatic step(input int k, input logic oe, input logic fr,
            input logic [3:0] nib);
        @(negedge sys_clk_in);
        host_oe_out = oe;
        lframe_n_out = fr;
        if (oe) begin
            host_lad_out = nib;
        end
        @(posedge sys_clk_in);
        seen[k] = lad_bus_in;
        seen_oe[k] = lad_oe_in;
    endtask

    // one memory cycle; abort_at of 0 runs it whole
    task automatic cycle(input logic [3:0] start, input logic [3:0] ctype,
            input logic [31:0] addr, input logic [7:0] wd, input int abort_at);
        int k;
        logic [3:0] nib;
        logic hd;
        for (k = 0; k <= 17; k++) begin
            seen[k] = 4'h0;
            seen_oe[k] = 1'b0;
        end
        for (k = 1; k <= 16; k++) begin
            // host owns the bus up to its turnaround
            hd = (k <= 11) || (ctype[1] && k <= 13);
            if (k == 1) begin
                nib = start;
            end else if (k == 2) begin
                nib = ctype;
            end else if (k <= 10) begin
                nib = addr[(10-k)*4 +: 4];
            end else if (ctype[1] && k == 11) begin
                nib = wd[3:0];
            end else if (ctype[1] && k == 12) begin
                nib = wd[7:4];
            end else begin
                nib = TAR_NIB;
            end
            if (k == abort_at) begin
                step(k, hd, 1'b0, TAR_NIB);
                step(k + 1, 1'b0, 1'b1, TAR_NIB);
                break;
            end
            step(k, hd, k != 1, nib);
        end
    endtask
endmodule

// [testbench/lpc_memory_cycle_target_tb.sv]
// self-checking bench for the lpc memory cycle target
// assumes lpc_host_model drives the host side of the bus
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    fail_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module lpc_memory_cycle_target_tb import lpc_target_pkg::*; ();
    logic clk;
    logic rst_n;
    logic [NIB_W-1:0] lad_bus;
    logic [NIB_W-1:0] lad_out;
    logic lad_oe;
    logic [NIB_W-1:0] host_lad;
    logic host_oe;
    logic frame_n;
    logic [STRAP_W-1:0] strap;
    logic req_valid, req_write, req_space, cap_write, cap_space;
    logic [ADDR_W-1:0] req_addr, cap_addr;
    logic [DATA_W-1:0] req_wdata, cap_wdata, rdata;
    int req_count, fail_count, samples_checked, seed, i, ab, k;

    // released wire shows the inverse of the last host nibble
    assign lad_bus = host_oe ? host_lad : (lad_oe ? lad_out : ~host_lad);

    lpc_memory_cycle_target u_dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .lad_in(lad_bus),
        .lframe_n_in(frame_n), .lad_out(lad_out), .lad_oe_out(lad_oe),
        .device_select_strap_in(strap), .req_valid_out(req_valid),
        .req_write_out(req_write), .req_reg_space_out(req_space),
        .req_addr_out(req_addr), .req_wdata_out(req_wdata),
        .rdata_in(rdata)
    );

    lpc_host_model u_host (
        .sys_clk_in(clk), .lad_bus_in(lad_bus), .lad_oe_in(lad_oe),
        .host_lad_out(host_lad), .host_oe_out(host_oe),
        .lframe_n_out(frame_n)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        if (req_valid === 1'b1) begin
            req_count++;
            cap_addr = req_addr;
            cap_write = req_write;
            cap_space = req_space;
            cap_wdata = req_wdata;
        end
        if (rst_n === 1'b1) `CHK(host_oe & lad_oe, 1'b0)
    end

    function automatic logic id_ok(logic [31:0] a);
        return {a[ID_HI_BIT:ID_LO_BIT], a[ID_SOLO_BIT]} === ~strap;
    endfunction

    function automatic logic [31:0] make_addr(logic match);
        logic [31:0] a;
        a = $urandom;
        a[31:26] = 6'h3F;
        {a[ID_HI_BIT:ID_LO_BIT], a[ID_SOLO_BIT]} =
            match ? ~strap : ~strap ^ (4'h1 << ($urandom % 4));
        return a;
    endfunction

    function automatic logic exp_oe(logic acc, logic wr, int k, int ab);
        if (!acc || (ab != 0 && k > ab)) return 1'b0;
        return wr ? (k >= 14 && k <= 16) : (k >= 12 && k <= 16);
    endfunction

    function automatic logic [3:0] exp_nib(logic wr, int k, logic [7:0] rd);
        if (k == (wr ? 15 : 13)) return READY_SYNC_FIELD;
        if (!wr && k == 14) return rd[3:0];
        if (!wr && k == 15) return rd[7:4];
        return TAR_NIB;
    endfunction

    task automatic set_strap(input logic [3:0] s);
        @(negedge clk);
        strap = s;
        repeat (3) @(negedge clk);
    endtask

    // one host cycle, then every device-side outcome compared
    task automatic run(input logic [3:0] st, input logic [3:0] ct,
            input logic [31:0] a, input int ab);
        logic [7:0] wd;
        logic [7:0] rd;
        logic acc;
        logic rq;
        logic eo;
        int base;
        int k;
        wd = 8'($urandom);
        rd = 8'($urandom);
        rdata <= rd;
        acc = st == START_MEM_NIB && ct[3:2] == CYC_MEM_BITS && id_ok(a);
        rq = acc && (ab == 0 || ab > (ct[1] ? 12 : 11));
        base = req_count;
        u_host.cycle(st, ct, a, wd, ab);
        `CHK(req_count != base, rq)
        if (rq) begin
            `CHK(cap_addr, a)
            `CHK(cap_write, ct[1])
            `CHK(cap_space, ~a[SPACE_BIT])
            if (ct[1]) `CHK(cap_wdata, wd)
        end
        for (k = 1; k <= (ab == 0 ? 16 : ab + 1); k++) begin
            eo = exp_oe(acc, ct[1], k, ab);
            `CHK(u_host.seen_oe[k], eo)
            if (eo) `CHK(u_host.seen[k], exp_nib(ct[1], k, rd))
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #50000;
        fail_count++;
        final_report();
    end

    initial begin
        rst_n = 1'b0;
        strap = STRAP_RST;
        rdata = DATA_RST;
        req_count = 0;
        fail_count = 0;
        samples_checked = 0;
        seed = $urandom(32'hdf70);
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        `CHK(lad_oe, 1'b0)
        `CHK(lad_out, LAD_RST)
        `CHK(req_valid, 1'b0)
        $display("test reset done");
        for (i = 0; i < 16; i++) begin
            set_strap(i[3:0]);
            run(4'h0, 4'h4, make_addr(1'b1), 0);
            run(4'h0, {2'b01, i[0], 1'b1}, make_addr(1'b0), 0);
        end
        $display("test strap sweep done");
        repeat (20) begin
            run(4'h0, {2'b01, 2'($urandom)}, make_addr($urandom % 4 != 0), 0);
            if ($urandom % 2) repeat (2) @(negedge clk);
        end
        $display("test random done");
        for (i = 0; i < 16; i++) begin
            run(4'h0, i[3:0], make_addr(1'b1), 0);
            run(i[3:0], 4'h5, make_addr(1'b1), 0);
        end
        $display("test field sweep done");
        for (ab = 3; ab <= 16; ab++) begin
            run(4'h0, 4'h4, make_addr(1'b1), ab);
            run(4'h0, 4'h6, make_addr(1'b1), ab);
        end
        $display("test abort done");
        // reset lands in clock 13 of a read; bus must be let go from clock 14
        fork
            u_host.cycle(4'h0, 4'h4, make_addr(1'b1), 8'h00, 0);
            begin
                repeat (13) @(negedge clk);
                rst_n = 1'b0;
                @(negedge clk);
                `CHK(lad_oe, 1'b0)
                rst_n = 1'b1;
            end
        join
        `CHK(u_host.seen[13], READY_SYNC_FIELD)
        for (k = 14; k <= 16; k++) begin
            `CHK(u_host.seen_oe[k], 1'b0)
        end
        $display("test mid-cycle reset done");
        final_report();
    end
endmodule
